// file: verilog/gpio_port_regs.svh
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

`define ADDR_PORT_DATA_LATCH 3'h0
`define ADDR_PIN_DIRECTION 3'h1
`define ADDR_PULL_DEVICE_ENABLE 3'h2
`define ADDR_SLEW_RATE_ENABLE 3'h3
`define ADDR_DRIVE_STRENGTH_SELECT 3'h4
`define ADDR_PIN_IRQ_STATUS_CONTROL 3'h5
`define ADDR_PIN_IRQ_SOURCE_SELECT 3'h6
`define ADDR_PIN_IRQ_POLARITY_SELECT 3'h7

`define BIT_IRQ_FLAG 3
`define BIT_IRQ_ACK 2
`define BIT_IRQ_ENABLE 1
`define BIT_IRQ_MODE 0

`define RESET_BYTE 8'h00
`define RESET_NIBBLE 4'h0

`endif

// file: verilog/gpio_port_pkg.sv
package gpio_port_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] nibble_t;
endpackage

// file: verilog/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Two-stage synchroniser for the four interrupt pins
module pin_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Pins
    input wire logic [3:0] pin_async,
    output logic [3:0] pin_synced
);
    typedef struct packed {
        logic [3:0] stage1;
        logic [3:0] stage2;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    always_comb begin
        next_state = state;
        if (clk_en) begin
            next_state.stage1 = pin_async;
            next_state.stage2 = state.stage1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pin_synced = state.stage2;
endmodule // pin_sync
`default_nettype wire

// file: verilog/port_b_gpio.sv
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_port_regs.svh"
module port_b_gpio (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pull_up_en,
    output logic [7:0] pull_down_en,
    output logic [7:0] slew_limit_en,
    output logic [7:0] high_drive_en,
    // Interrupt request
    output logic irq_request
);
    typedef struct packed {
        gpio_port_pkg::byte_t port_data_latch;
        gpio_port_pkg::byte_t pin_direction;
        gpio_port_pkg::byte_t pull_device_enable;
        gpio_port_pkg::byte_t slew_rate_enable;
        gpio_port_pkg::byte_t drive_strength_select;
        gpio_port_pkg::nibble_t pin_irq_source_select;
        gpio_port_pkg::nibble_t pin_irq_polarity_select;
        logic pin_irq_flag;
        logic pin_irq_enable;
        logic pin_irq_detect_mode;
        gpio_port_pkg::nibble_t prev_active;
        gpio_port_pkg::byte_t rdata;
        gpio_port_pkg::byte_t out_q;
        gpio_port_pkg::byte_t oe_q;
        gpio_port_pkg::byte_t pu_q;
        gpio_port_pkg::byte_t pd_q;
        gpio_port_pkg::byte_t slew_q;
        gpio_port_pkg::byte_t drive_q;
        logic irq_q;
    } port_state_t;

    port_state_t state;
    port_state_t next_state;
    logic [3:0] irq_pins;

    // Active level per pin after polarity
    function automatic logic [3:0] active_level(input logic [3:0] lvl, input logic [3:0] pol);
        active_level = ~(lvl ^ pol);
    endfunction

    pin_sync u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin_async(pin_in[3:0]),
        .pin_synced(irq_pins)
    );

    logic [3:0] active_now;
    logic [3:0] edge_hit;
    logic detect;
    logic ack_write;

    always_comb begin
        next_state = state;
        active_now = active_level(irq_pins, state.pin_irq_polarity_select) & state.pin_irq_source_select;
        edge_hit = active_now & ~state.prev_active;
        detect = (|edge_hit) || (state.pin_irq_detect_mode && (|active_now));
        ack_write = reg_write && reg_addr == `ADDR_PIN_IRQ_STATUS_CONTROL && reg_wdata[`BIT_IRQ_ACK];
        if (clk_en) begin
            next_state.prev_active = active_now;
            if (reg_write) begin
                case (reg_addr)
                    `ADDR_PORT_DATA_LATCH: next_state.port_data_latch = reg_wdata;
                    `ADDR_PIN_DIRECTION: next_state.pin_direction = reg_wdata;
                    `ADDR_PULL_DEVICE_ENABLE: next_state.pull_device_enable = reg_wdata;
                    `ADDR_SLEW_RATE_ENABLE: next_state.slew_rate_enable = reg_wdata;
                    `ADDR_DRIVE_STRENGTH_SELECT: next_state.drive_strength_select = reg_wdata;
                    `ADDR_PIN_IRQ_STATUS_CONTROL: begin
                        next_state.pin_irq_enable = reg_wdata[`BIT_IRQ_ENABLE];
                        next_state.pin_irq_detect_mode = reg_wdata[`BIT_IRQ_MODE];
                    end
                    `ADDR_PIN_IRQ_SOURCE_SELECT: next_state.pin_irq_source_select = reg_wdata[3:0];
                    `ADDR_PIN_IRQ_POLARITY_SELECT: next_state.pin_irq_polarity_select = reg_wdata[3:0];
                    default: next_state.port_data_latch = state.port_data_latch;
                endcase
            end
            // Detection wins over acknowledge
            if (ack_write) begin
                next_state.pin_irq_flag = 1'b0;
            end
            if (detect) begin
                next_state.pin_irq_flag = 1'b1;
            end
            next_state.rdata = 8'h00;
            if (reg_read) begin
                case (reg_addr)
                    `ADDR_PORT_DATA_LATCH: next_state.rdata = (state.pin_direction & state.port_data_latch)
                        | (~state.pin_direction & pin_in);
                    `ADDR_PIN_DIRECTION: next_state.rdata = state.pin_direction;
                    `ADDR_PULL_DEVICE_ENABLE: next_state.rdata = state.pull_device_enable;
                    `ADDR_SLEW_RATE_ENABLE: next_state.rdata = state.slew_rate_enable;
                    `ADDR_DRIVE_STRENGTH_SELECT: next_state.rdata = state.drive_strength_select;
                    `ADDR_PIN_IRQ_STATUS_CONTROL: next_state.rdata = {4'h0, state.pin_irq_flag, 1'b0,
                        state.pin_irq_enable, state.pin_irq_detect_mode};
                    `ADDR_PIN_IRQ_SOURCE_SELECT: next_state.rdata = {4'h0, state.pin_irq_source_select};
                    `ADDR_PIN_IRQ_POLARITY_SELECT: next_state.rdata = {4'h0, state.pin_irq_polarity_select};
                    default: next_state.rdata = 8'h00;
                endcase
            end
            next_state.out_q = next_state.port_data_latch;
            next_state.oe_q = next_state.pin_direction;
            next_state.pd_q = ~next_state.pin_direction & next_state.pull_device_enable
                & {4'h0, next_state.pin_irq_source_select & next_state.pin_irq_polarity_select};
            next_state.pu_q = ~next_state.pin_direction & next_state.pull_device_enable
                & ~{4'h0, next_state.pin_irq_source_select & next_state.pin_irq_polarity_select};
            next_state.slew_q = next_state.pin_direction & next_state.slew_rate_enable;
            next_state.drive_q = next_state.pin_direction & next_state.drive_strength_select;
            next_state.irq_q = next_state.pin_irq_flag & next_state.pin_irq_enable;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;
    assign pin_out = state.out_q;
    assign pin_oe = state.oe_q;
    assign pull_up_en = state.pu_q;
    assign pull_down_en = state.pd_q;
    assign slew_limit_en = state.slew_q;
    assign high_drive_en = state.drive_q;
    assign irq_request = state.irq_q;

    chk_irq_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
        irq_request |-> state.pin_irq_flag && state.pin_irq_enable) else $error("irq without flag and enable");
    chk_ack_reads_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && reg_read && reg_addr == `ADDR_PIN_IRQ_STATUS_CONTROL |=> !reg_rdata[`BIT_IRQ_ACK])
        else $error("ack bit read as one");
    chk_flag_set_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && (|edge_hit) |=> state.pin_irq_flag) else $error("edge did not set flag");
    chk_flag_cleared: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && ack_write && !detect |=> !state.pin_irq_flag) else $error("ack did not clear flag");
    chk_level_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && state.pin_irq_detect_mode && (|active_now) |=> state.pin_irq_flag)
        else $error("level mode lost flag");
    chk_no_set_edge_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && !state.pin_irq_flag && !state.pin_irq_detect_mode && edge_hit == 4'h0 |=> !state.pin_irq_flag)
        else $error("flag set without edge");
    chk_output_pulls_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        ((pull_up_en | pull_down_en) & pin_oe) == 8'h00) else $error("pull on output pin");
    chk_pulldown_select: assert property (@(posedge core_clk) disable iff (!rst_n)
        pull_down_en[7:4] == 4'h0) else $error("pull-down on non-irq pin");
    chk_slew_input: assert property (@(posedge core_clk) disable iff (!rst_n)
        ((slew_limit_en | high_drive_en) & ~pin_oe) == 8'h00) else $error("slew or drive on input");
    chk_data_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && reg_read && reg_addr == `ADDR_PORT_DATA_LATCH |=>
        reg_rdata == (($past(state.pin_direction) & $past(state.port_data_latch))
        | (~$past(state.pin_direction) & $past(pin_in)))) else $error("data read wrong");
endmodule // port_b_gpio
`default_nettype wire

// file: sim/pin_partner.sv
`timescale 1ns/1ns
`default_nettype none
// Outside world of the pins
module pin_partner (
    // Clock
    input wire logic core_clk,
    // Device side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_up_en,
    input wire logic [7:0] pull_down_en,
    // Outside drivers
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_lvl
);
    logic [7:0] float_v = 8'h55;
    always_ff @(posedge core_clk) float_v <= ~float_v;
    always_comb pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pull_up_en | (~pull_down_en & float_v)));
endmodule // pin_partner
`default_nettype wire

// file: sim/port_b_gpio_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module port_b_gpio_tb_top;
    logic core_clk, rst_n, clk_en, reg_write, reg_read, irq_request;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, pull_up_en, pull_down_en;
    logic [7:0] slew_limit_en, high_drive_en, ext_en, ext_val, rv;
    logic [7:0] mdl [8];
    int error_cnt, num_checks, i;
    port_b_gpio port_b_gpio_inst (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .slew_limit_en(slew_limit_en), .high_drive_en(high_drive_en),
        .irq_request(irq_request));
    pin_partner pin_partner_inst (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .ext_en(ext_en), .ext_val(ext_val),
        .pin_lvl(pin_in));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
        mdl[a] = (a >= 3'h6) ? (d & 8'h0f) : d;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk_pins;
        logic [7:0] p, s;
        #1 p = mdl[2] & ~mdl[1];
        s = mdl[6] & mdl[7];
        check(pin_oe, mdl[1]);
        check(pin_out, mdl[0]);
        check(pull_down_en, p & s);
        check(pull_up_en, p & ~s);
        check(slew_limit_en, mdl[3] & mdl[1]);
        check(high_drive_en, mdl[4] & mdl[1]);
    endtask
    task automatic wait_irq;
        for (int n = 0; n < 8 && irq_request !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        check({7'h00, irq_request}, 8'h01);
    endtask
    task automatic rd_sc(input logic [7:0] exp);
        rd(3'h5, rv);
        check(rv, exp);
    endtask
    initial begin
        #(20 * 4000);
        error_cnt++;
        end_sim;
    end
    initial begin
        rst_n = 1'b0;
        {reg_write, reg_read, reg_addr, reg_wdata} = '0;
        clk_en = 1'b1;
        ext_en = 8'hff;
        ext_val = 8'h00;
        foreach (mdl[k]) mdl[k] = 8'h00;
        void'($urandom(32'h67e2));
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        chk_pins;
        for (i = 0; i < 8; i++) begin
            rd(i[2:0], rv);
            check(rv, 8'h00);
        end
        for (i = 0; i < 24; i++) begin
            for (int a = 0; a < 8; a++) begin
                if (a != 5) wr(a[2:0], 8'($urandom));
            end
            ext_en <= ~mdl[1];
            ext_val <= 8'($urandom);
            chk_pins;
            for (int a = 0; a < 8; a++) begin
                rd(a[2:0], rv);
                if (a == 0) check(rv, (mdl[1] & mdl[0]) | (~mdl[1] & ext_val));
                else if (a != 5) check(rv, mdl[a]);
            end
        end
        wr(3'h1, 8'h00);
        wr(3'h6, 8'h00);
        wr(3'h7, 8'h00);
        ext_en <= 8'hff;
        ext_val <= 8'hff;
        wr(3'h6, 8'h01);
        wr(3'h5, 8'h06);
        ext_val <= 8'hfe;
        wait_irq;
        rd_sc(8'h0a);
        wr(3'h5, 8'h0e);
        rd_sc(8'h02);
        wr(3'h5, 8'h0a);
        rd_sc(8'h02);
        wr(3'h5, 8'h07);
        wait_irq;
        rd_sc(8'h0b);
        wr(3'h5, 8'h01);
        #1;
        check({7'h00, irq_request}, 8'h00);
        rd_sc(8'h09);
        ext_val <= 8'hff;
        repeat (4) @(posedge core_clk);
        wr(3'h5, 8'h05);
        rd_sc(8'h01);
        ext_val <= 8'hfd;
        repeat (6) @(posedge core_clk);
        rd_sc(8'h01);
        wr(3'h7, 8'h02);
        wr(3'h6, 8'h02);
        wr(3'h2, 8'h03);
        wr(3'h5, 8'h06);
        chk_pins;
        ext_en <= 8'hfe;
        ext_val <= 8'hff;
        wait_irq;
        rd_sc(8'h0a);
        clk_en <= 1'b0;
        wr(3'h1, 8'hff);
        clk_en <= 1'b1;
        mdl[1] = 8'h00;
        rd(3'h1, rv);
        check(rv, 8'h00);
        end_sim;
    end
endmodule // port_b_gpio_tb_top
`default_nettype wire
